// *** verilog/cmpd_pkg.sv ***
`default_nettype none
package cmpd_pkg;
    // Clock and strap settle timing
    localparam int CLOCK_MHZ = 200;
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] SETTLE_COUNT = CNT_W'(SETTLE_CYCLES);

    // Register bus layout
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] PINS_ADDR = 4'h8;
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int STAT_CHANGED_BIT = 8;
    localparam int CFG_W = 7;
    localparam int STRAP_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Resolved level of a three-level strap, one-hot
    typedef enum logic [2:0] {
        TRI_LOW = 3'h1,
        TRI_MID = 3'h2,
        TRI_HIGH = 3'h4
    } cmpd_tri_t;

    // Comparator pair per strap: bit 1 above upper threshold, bit 0 above lower
    typedef struct packed {
        logic [1:0] modeSelect;
        logic [1:0] secondarySelect;
        logic [1:0] outputDifferentialSwing;
        logic [1:0] outputEdgeSelect;
        logic [1:0] samplingMode;
        logic [1:0] inputFullScaleRange;
    } cmpd_straps_t;

    // Applied configuration
    typedef struct packed {
        logic strapUndefined;
        logic reducedFullScale;
        logic dualEdgeSampling;
        logic ddrClock;
        logic risingEdgeLaunch;
        logic reducedSwing;
        logic extendedMode;
    } cmpd_cfg_t;

    localparam cmpd_cfg_t CFG_RESET = '0;
    localparam cmpd_straps_t STRAPS_RESET = '0;
endpackage
`default_nettype wire

// *** verilog/cmpd_control_mode_pin_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - Mode pin high forces pin-programmed mode
// - Mode mid, secondary not low: range pin decides
// - Swing pin low reduced, high normal swing
// - Edge pin low falling, high rising launch
// - Edge pin mid selects DDR output clock
// - Sampling pin mid selects dual edge sampling
// - Range pin low reduced, high normal, mid extended with mode mid and secondary not low
// - Extended: sampling pin is serial select
module cmpd_control_mode_pin_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Strap comparator pairs from the pads
    input wire cmpd_pkg::cmpd_straps_t straps,
    // Applied configuration
    output cmpd_pkg::cmpd_cfg_t cfg,
    // Serial port pins handed on in extended mode
    output logic serialPortClock,
    output logic serialPortData,
    output logic serialPortSelect_b,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [cmpd_pkg::ADDR_W-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [cmpd_pkg::ADDR_W-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // Inconsistent comparator pairs count as mid, so they take whatever setting a mid pin selects
    function automatic cmpd_pkg::cmpd_tri_t triLevel(input logic [1:0] cmp);
        case (cmp)
            2'h0: triLevel = cmpd_pkg::TRI_LOW;
            2'h3: triLevel = cmpd_pkg::TRI_HIGH;
            default: triLevel = cmpd_pkg::TRI_MID;
        endcase
    endfunction

    cmpd_pkg::cmpd_straps_t syncA_q;
    cmpd_pkg::cmpd_straps_t syncB_q;
    cmpd_pkg::cmpd_straps_t prev_q;
    logic [cmpd_pkg::CNT_W-1:0] settle_q;
    logic [cmpd_pkg::CNT_W-1:0] settle_d;
    cmpd_pkg::cmpd_cfg_t cfg_q;
    cmpd_pkg::cmpd_cfg_t cfg_d;
    logic freeze_q;
    logic changed_q;

    // Pads are asynchronous; only syncB_q is read by logic
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= cmpd_pkg::STRAPS_RESET;
            syncB_q <= cmpd_pkg::STRAPS_RESET;
            prev_q <= cmpd_pkg::STRAPS_RESET;
        end else begin
            syncA_q <= straps;
            syncB_q <= syncA_q;
            prev_q <= syncB_q;
        end
    end

    // Resolved strap levels
    cmpd_pkg::cmpd_tri_t modeT;
    cmpd_pkg::cmpd_tri_t secT;
    cmpd_pkg::cmpd_tri_t swT;
    cmpd_pkg::cmpd_tri_t edT;
    cmpd_pkg::cmpd_tri_t smT;
    cmpd_pkg::cmpd_tri_t fsT;
    assign modeT = triLevel(syncB_q.modeSelect);
    assign secT = triLevel(syncB_q.secondarySelect);
    assign swT = triLevel(syncB_q.outputDifferentialSwing);
    assign edT = triLevel(syncB_q.outputEdgeSelect);
    assign smT = triLevel(syncB_q.samplingMode);
    assign fsT = triLevel(syncB_q.inputFullScaleRange);

    // Mode choice; pin functions clear in extended mode since the serial port owns them
    logic secOk;
    logic extD;
    assign secOk = (secT != cmpd_pkg::TRI_LOW);
    assign extD = secOk && ((modeT == cmpd_pkg::TRI_LOW)
        || (modeT == cmpd_pkg::TRI_MID && fsT == cmpd_pkg::TRI_MID));
    assign cfg_d.extendedMode = extD;
    assign cfg_d.reducedSwing = !extD && swT == cmpd_pkg::TRI_LOW;
    assign cfg_d.risingEdgeLaunch = !extD && edT == cmpd_pkg::TRI_HIGH;
    assign cfg_d.ddrClock = !extD && edT == cmpd_pkg::TRI_MID;
    assign cfg_d.dualEdgeSampling = !extD && smT == cmpd_pkg::TRI_MID;
    assign cfg_d.reducedFullScale = !extD && fsT == cmpd_pkg::TRI_LOW;
    // Flags straps with no defined meaning, including a low sampling pin
    assign cfg_d.strapUndefined = !extD && (swT == cmpd_pkg::TRI_MID
        || smT == cmpd_pkg::TRI_LOW);

    // Settle counter restarts on any strap movement, so glitches never reach the core
    logic moved;
    logic applyNow;
    assign moved = (syncB_q != prev_q);
    assign settle_d = moved ? '0 : (settle_q == cmpd_pkg::SETTLE_COUNT) ? settle_q : settle_q + 1'b1;
    assign applyNow = !moved && settle_q == cmpd_pkg::SETTLE_COUNT && !freeze_q;

    // Configuration only moves when straps have been still for the settle time
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            settle_q <= '0;
            cfg_q <= cmpd_pkg::CFG_RESET;
        end else begin
            settle_q <= settle_d;
            if (applyNow) begin
                cfg_q <= cfg_d;
            end
        end
    end
    assign cfg = cfg_q;

    // Serial pins pass through only in extended mode; select idles high otherwise
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            serialPortClock <= 1'b0;
            serialPortData <= 1'b0;
            serialPortSelect_b <= 1'b1;
        end else begin
            serialPortClock <= cfg_q.extendedMode && syncB_q.outputDifferentialSwing[1];
            serialPortData <= cfg_q.extendedMode && syncB_q.outputEdgeSelect[1];
            serialPortSelect_b <= !cfg_q.extendedMode || syncB_q.samplingMode[1];
        end
    end

    // Write channel: address and data latched independently, response after both
    logic awHeld_q;
    logic wHeld_q;
    logic [cmpd_pkg::ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic wrCtrl;
    logic wrStatus;
    logic wrKnown;
    logic changeEvent;
    logic changedClr;
    assign awready = !awHeld_q && !bvalid;
    assign wready = !wHeld_q && !bvalid;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign wrCtrl = doWrite && awAddr_q == cmpd_pkg::CTRL_ADDR && wStrb_q[0];
    assign wrStatus = doWrite && awAddr_q == cmpd_pkg::STATUS_ADDR;
    assign wrKnown = awAddr_q == cmpd_pkg::CTRL_ADDR || awAddr_q == cmpd_pkg::STATUS_ADDR
        || awAddr_q == cmpd_pkg::PINS_ADDR;
    assign changedClr = wrStatus && wStrb_q[1] && wData_q[cmpd_pkg::STAT_CHANGED_BIT];
    assign changeEvent = applyNow && cfg_d != cfg_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bvalid <= 1'b0;
            bresp <= cmpd_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrKnown ? cmpd_pkg::RESP_OKAY : cmpd_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Freeze lets software pin the configuration while straps are reworked; set beats clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            freeze_q <= 1'b0;
            changed_q <= 1'b0;
        end else begin
            if (wrCtrl) begin
                freeze_q <= wData_q[cmpd_pkg::CTRL_FREEZE_BIT];
            end
            changed_q <= changeEvent || (changed_q && !changedClr);
        end
    end

    // Read channel: one read at a time, data registered
    logic [31:0] rdMux;
    assign arready = !rvalid;
    assign rdMux = (araddr == cmpd_pkg::CTRL_ADDR) ? {31'h0, freeze_q}
        : (araddr == cmpd_pkg::STATUS_ADDR) ? {23'h0, changed_q, 1'b0, cfg_q}
        : (araddr == cmpd_pkg::PINS_ADDR) ? {20'h0, syncB_q}
        : 32'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= cmpd_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= (araddr == cmpd_pkg::CTRL_ADDR || araddr == cmpd_pkg::STATUS_ADDR
                || araddr == cmpd_pkg::PINS_ADDR) ? cmpd_pkg::RESP_OKAY : cmpd_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks on the applied configuration and serial pin routing
    a_pin_mode_high: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && modeT == cmpd_pkg::TRI_HIGH |=> !cfg_q.extendedMode)
        else $error("mode pin high did not give pin mode");
    a_range_decides_mode: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && modeT == cmpd_pkg::TRI_MID && secOk && fsT == cmpd_pkg::TRI_MID
        |=> cfg_q.extendedMode && !cfg_q.reducedFullScale)
        else $error("range pin mid did not give extended mode");
    a_swing_level: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && !extD |=> cfg_q.reducedSwing == $past(swT == cmpd_pkg::TRI_LOW))
        else $error("swing setting wrong");
    a_edge_select: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && !extD && edT == cmpd_pkg::TRI_HIGH |=> cfg_q.risingEdgeLaunch && !cfg_q.ddrClock)
        else $error("edge pin high did not give rising launch");
    a_ddr_clock: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && !extD && edT == cmpd_pkg::TRI_MID |=> cfg_q.ddrClock && !cfg_q.risingEdgeLaunch)
        else $error("edge pin mid did not give DDR");
    a_dual_edge: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && !extD && smT == cmpd_pkg::TRI_MID |=> cfg_q.dualEdgeSampling)
        else $error("sampling pin mid did not give dual edge");
    a_full_scale: assert property (@(posedge clock) disable iff (!rst_b)
        applyNow && !extD && fsT == cmpd_pkg::TRI_LOW |=> cfg_q.reducedFullScale && !cfg_q.extendedMode)
        else $error("range pin low did not give reduced range");
    a_serial_route: assert property (@(posedge clock) disable iff (!rst_b)
        cfg_q.extendedMode && syncB_q.outputDifferentialSwing[1] && !syncB_q.outputEdgeSelect[1]
        |=> serialPortClock && !serialPortData)
        else $error("serial clock or data not routed");
    a_serial_select: assert property (@(posedge clock) disable iff (!rst_b)
        !cfg_q.extendedMode |=> serialPortSelect_b)
        else $error("serial select active outside extended mode");
    a_settle_hold: assert property (@(posedge clock) disable iff (!rst_b)
        moved |=> !applyNow [*8])
        else $error("configuration applied before straps settled");
    a_freeze_hold: assert property (@(posedge clock) disable iff (!rst_b)
        freeze_q |=> $stable(cfg_q))
        else $error("configuration moved while frozen");
endmodule
`default_nettype wire

// *** tb/cmpd_strap_board.sv ***
`timescale 1ns/1ps
`default_nettype none
// Board straps or host: each pin level becomes the pad comparator pair
module cmpd_strap_board (
    // Pin levels, 0 low, 1 mid, 2 high, mode pin first
    input wire logic [11:0] levels,
    // Comparator pairs to the decoder
    output cmpd_pkg::cmpd_straps_t straps
);
    // Mid sits between the thresholds, so only the lower comparator trips
    function automatic logic [1:0] pair(input logic [1:0] l);
        return (l == 2'h0) ? 2'h0 : (l == 2'h1) ? 2'h1 : 2'h3;
    endfunction
    // In extended mode the host drives clock, data and select on these same pins
    assign straps = {pair(levels[11:10]), pair(levels[9:8]), pair(levels[7:6]),
                     pair(levels[5:4]), pair(levels[3:2]), pair(levels[1:0])};
endmodule
`default_nettype wire

// *** tb/tb_control_mode_pin_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_control_mode_pin_decoder;
    localparam logic [1:0] L = 2'h0;
    localparam logic [1:0] M = 2'h1;
    localparam logic [1:0] H = 2'h2;
    // Stimulus and observed signals
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] levels = {H, H, H, H, H, H};
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0;
    cmpd_pkg::cmpd_straps_t straps;
    cmpd_pkg::cmpd_cfg_t cfg;
    logic spClk, spData, spSel_b, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int failures = 0;
    int samples_checked = 0;

    cmpd_strap_board cmpd_strap_board_inst (.levels(levels), .straps(straps));
    cmpd_control_mode_pin_decoder cmpd_control_mode_pin_decoder_inst (.clock(clock), .rst_b(rst_b),
        .straps(straps), .cfg(cfg), .serialPortClock(spClk), .serialPortData(spData),
        .serialPortSelect_b(spSel_b), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    // 200 MHz clock
    initial forever #2.5 clock = ~clock;

    task automatic final_report;
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Decode worked out from the pin tables; extended mode hides pin fields
    function automatic logic [6:0] expc(input logic [11:0] v);
        logic [1:0] m, s, sw, e, smp, r;
        {m, s, sw, e, smp, r} = v;
        if (s != L && (m == L || (m == M && r == M))) return 7'h01;
        return {sw == M || smp == L, r == L, smp == M, e == M, e == H, sw == L, 1'b0};
    endfunction

    task automatic strap(input logic [11:0] v, input int n);
        levels <= v;
        repeat (n) @(posedge clock);
    endtask

    // Settle takes about 204 edges, so 260 leaves margin
    task automatic pinchk(input logic [11:0] v);
        strap(v, 260);
        chk({25'h0, cfg}, {25'h0, expc(v)});
    endtask

    task automatic spchk(input logic [2:0] e);
        chk({29'h0, spClk, spData, spSel_b}, {29'h0, e});
    endtask

    // Bus write: both channels offered together, each released when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, v;
        logic [1:0] r;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            v = bvalid;
            r = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (v) break;
        end
        // A write that never answers is a mismatch, not a silent pass
        if (!v) begin
            failures++;
            $display("[FAIL] %0t write response never came", $time);
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Bus read with expected data and response
    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic t, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clock);
            t = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (t) arvalid <= 1'b0;
            if (v) break;
        end
        // A read that never answers is a mismatch, not a silent pass
        if (!v) begin
            failures++;
            $display("[FAIL] %0t read data never came", $time);
        end
        rready <= 1'b0;
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // Pin-programmed decode over every level of every strap but the mode pin, held high
    task automatic t_pin;
        pinchk({H, H, H, H, H, H});
        pinchk({H, H, L, L, M, L});
        pinchk({H, M, M, M, L, H});
        pinchk({H, L, H, H, H, M});
        spchk(3'h1);
    endtask

    // Mode selection and serial pin hand-over
    task automatic t_ext;
        pinchk({M, H, H, H, H, M});
        pinchk({M, L, H, H, H, M});
        pinchk({M, M, L, H, H, H});
        pinchk({L, M, L, L, H, H});
        spchk(3'h1);
        strap({L, M, H, L, L, H}, 4);
        spchk(3'h4);
        strap({L, M, L, H, L, H}, 4);
        spchk(3'h2);
    endtask

    // Status, unmapped places, pin readback and freeze
    task automatic t_bus;
        axr(cmpd_pkg::STATUS_ADDR, 32'h101, cmpd_pkg::RESP_OKAY);
        axw(cmpd_pkg::STATUS_ADDR, 32'h100, cmpd_pkg::RESP_OKAY);
        axr(cmpd_pkg::STATUS_ADDR, 32'h1, cmpd_pkg::RESP_OKAY);
        axr(4'hc, 32'h0, cmpd_pkg::RESP_SLVERR);
        axw(4'hc, 32'h1, cmpd_pkg::RESP_SLVERR);
        axw(cmpd_pkg::PINS_ADDR, 32'hfff, cmpd_pkg::RESP_OKAY);
        axr(cmpd_pkg::PINS_ADDR, 32'h133, cmpd_pkg::RESP_OKAY);
        axw(cmpd_pkg::CTRL_ADDR, 32'h1, cmpd_pkg::RESP_OKAY);
        axr(cmpd_pkg::CTRL_ADDR, 32'h1, cmpd_pkg::RESP_OKAY);
        strap({H, H, H, H, H, H}, 260);
        chk({25'h0, cfg}, 32'h1);
        axw(cmpd_pkg::CTRL_ADDR, 32'h0, cmpd_pkg::RESP_OKAY);
        strap({H, H, H, H, H, H}, 20);
        chk({25'h0, cfg}, 32'h4);
    endtask

    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        t_pin();
        t_ext();
        t_bus();
        final_report();
    end

    // Watchdog well beyond the roughly 12 us of tests
    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
